// ---- include/hcw_pkg.sv ----
// Behaviour
// [R1] sync field one enables multi-device timing; zero disables it
// [R2] write guard set: ignore writes except to control and reference registers
// [R3] write guard acts only while output-activate is one
// [R4] 3-bit rate code selects 1024 down to 16 ksps, halving per step
// [R5] selected rate paces direct, queue and stored-memory playback alike
// [R6] output-activate enables play or sense; else low-power selects idle or sleep
package hcw_pkg;
  localparam logic [3:0] CONTROL_WORD_ADDR = 4'h5;
  localparam logic [3:0] REFERENCE_ADDR = 4'h3;
  localparam logic [11:0] CONTROL_WORD_RESET = 12'h000;
  localparam int CLK_HZ = 50000000;
  localparam int RATE_MAX_SPS = 1024000;
  // cycles per sample at the fastest code; slower codes double it per step
  localparam int BASE_DIV = CLK_HZ / RATE_MAX_SPS;
  localparam logic [15:0] BASE_DIV_CYCLES = 16'(BASE_DIV);
  localparam logic [2:0] RATE_CODE_SLOWEST = 3'h6;

  typedef enum logic [1:0] {
    HCW_ACTIVE,
    HCW_IDLE,
    HCW_SLEEP
  } hcw_power_e;

  typedef struct packed {
    logic [3:0] upper_bits;
    logic sync_enable;
    logic write_guard;
    logic reset_bit;
    logic output_activate;
    logic low_power_select;
    logic [2:0] rate_code;
  } hcw_ctrl_s;

  typedef struct packed {
    hcw_ctrl_s ctrl;
    hcw_power_e power;
    logic [15:0] tick_count;
    logic sample_tick;
  } hcw_state_s;
endpackage

// ---- verilog/hcw_control_word.sv ----
`timescale 1ns/1ps
`default_nettype none
module hcw_control_word (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [3:0] wr_addr_in,
  input wire logic [11:0] wr_data_in,
  output logic [11:0] control_word_out,
  output logic wr_allowed_out,
  output logic sync_enable_out,
  output logic play_enable_out,
  output logic sleep_out,
  output logic idle_out,
  output logic sleep_clear_out,
  output logic sample_tick_out,
  output logic [15:0] sample_div_out
);
  // all state sits in one struct: one comb process builds the next copy, one flop stage holds it
  hcw_pkg::hcw_state_s state;
  hcw_pkg::hcw_state_s next_state;
  logic guard_on;
  logic [15:0] div_now;

  // registers exempt from the write guard: the control word itself and the reference
  function automatic logic is_exempt_addr(input logic [3:0] addr);
    is_exempt_addr = (addr == hcw_pkg::CONTROL_WORD_ADDR)
      || (addr == hcw_pkg::REFERENCE_ADDR);
  endfunction

  // a strobe aimed at the control word; shared by the update and by the checks
  function automatic logic is_control_write(input logic en, input logic [3:0] addr);
    is_control_write = en && (addr == hcw_pkg::CONTROL_WORD_ADDR);
  endfunction

  // cycles per sample; code 7 has no rate of its own, so it runs at the slowest one
  function automatic logic [15:0] rate_div(input logic [2:0] code);
    logic [2:0] c;
    c = (code > hcw_pkg::RATE_CODE_SLOWEST) ? hcw_pkg::RATE_CODE_SLOWEST : code;
    rate_div = 16'(hcw_pkg::BASE_DIV_CYCLES << c);
  endfunction

  // guard only bites while output is active, control/reference exempt
  assign guard_on = state.ctrl.write_guard && state.ctrl.output_activate; // [R3]
  // other register blocks gate their writes on this; this block stores nothing else
  assign wr_allowed_out = !guard_on || is_exempt_addr(wr_addr_in); // [R2]
  assign div_now = rate_div(state.ctrl.rate_code); // [R4]

  // next state: register write, power mode and sample pacing
  always_comb begin
    next_state = state;
    next_state.sample_tick = 1'b0;
    // the control word is taken even under the guard, so the host can always unlock
    if (is_control_write(wr_en_in, wr_addr_in)) begin
      next_state.ctrl = hcw_pkg::hcw_ctrl_s'(wr_data_in);
    end
    // power follows the new word at once, so mode and word never disagree
    if (next_state.ctrl.output_activate) begin
      next_state.power = hcw_pkg::HCW_ACTIVE; // [R6]
    end else if (next_state.ctrl.low_power_select) begin
      next_state.power = hcw_pkg::HCW_SLEEP; // [R6]
    end else begin
      next_state.power = hcw_pkg::HCW_IDLE;
    end
    // one divider serves every playback mode, so rates match across them
    if (state.power == hcw_pkg::HCW_ACTIVE) begin
      if (state.tick_count >= div_now - 16'h0001) begin
        next_state.tick_count = 16'h0000;
        next_state.sample_tick = 1'b1; // [R5]
      end else begin
        next_state.tick_count = state.tick_count + 16'h0001;
      end
    end else begin
      next_state.tick_count = 16'h0000;
    end
  end

  // synchronous reset; the reset branch loads constants only
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state.ctrl <= hcw_pkg::hcw_ctrl_s'(hcw_pkg::CONTROL_WORD_RESET);
      state.power <= hcw_pkg::HCW_IDLE;
      state.tick_count <= 16'h0000;
      state.sample_tick <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs come straight from the state flops or from decode of them
  assign control_word_out = state.ctrl;
  assign sync_enable_out = state.ctrl.sync_enable; // [R1]
  assign play_enable_out = state.power == hcw_pkg::HCW_ACTIVE;
  assign sleep_out = state.power == hcw_pkg::HCW_SLEEP;
  assign idle_out = state.power == hcw_pkg::HCW_IDLE;
  // sleep asks the rest of the device to clear registers and memory
  assign sleep_clear_out = sleep_out; // [R6]
  assign sample_tick_out = state.sample_tick;
  assign sample_div_out = div_now;

  // write steps shared by the checks below
  sequence s_ctrl_write;
    is_control_write(wr_en_in, wr_addr_in);
  endsequence

  sequence s_sleep_write;
    is_control_write(wr_en_in, wr_addr_in) && !wr_data_in[4] && wr_data_in[3];
  endsequence

  sequence s_active_write;
    is_control_write(wr_en_in, wr_addr_in) && wr_data_in[4];
  endsequence

  sequence s_idle_write;
    is_control_write(wr_en_in, wr_addr_in) && !wr_data_in[4] && !wr_data_in[3];
  endsequence

  sequence s_guarded_other;
    state.ctrl.write_guard && state.ctrl.output_activate && !is_exempt_addr(wr_addr_in);
  endsequence

  // a guarded register sees its write refused while output is active
  a_guard_blocks: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R2]
    s_guarded_other |-> !wr_allowed_out)
    else $error("guarded write allowed");

  // the exempt registers stay writable whatever the guard says
  a_guard_exempt: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R2]
    is_exempt_addr(wr_addr_in) |-> wr_allowed_out)
    else $error("exempt register refused");

  // with output off the guard has no effect
  a_guard_inactive: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R3]
    !state.ctrl.output_activate |-> wr_allowed_out)
    else $error("write refused with output off");

  // a control write lands one cycle later
  a_ctrl_write: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R1]
    s_ctrl_write |=> control_word_out == $past(wr_data_in))
    else $error("control write lost");

  // the sync output follows bit 7 of the last control write
  a_sync_follow: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R1]
    s_ctrl_write |=> sync_enable_out == $past(wr_data_in[7]))
    else $error("sync enable wrong");

  // without a control write the word holds
  a_word_holds: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R1]
    !is_control_write(wr_en_in, wr_addr_in) |=> $stable(control_word_out))
    else $error("control word changed");

  // fastest code paces one sample every 48 clocks
  a_rate_fast: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R4]
    state.ctrl.rate_code == 3'h0 |-> sample_div_out == 16'h0030)
    else $error("fastest rate divider wrong");

  // slowest code is 64 times the fastest period
  a_rate_slow: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R4]
    state.ctrl.rate_code == 3'h6 |-> sample_div_out == 16'h0c00)
    else $error("slowest rate divider wrong");

  // one divider check per rate code, the undefined code clamped to the slowest
  for (genvar k = 0; k < 8; k++) begin : g_rate_chk
    localparam int SHIFT = (k > int'(hcw_pkg::RATE_CODE_SLOWEST))
      ? int'(hcw_pkg::RATE_CODE_SLOWEST) : k;
    localparam logic [15:0] EXP_DIV = 16'(hcw_pkg::BASE_DIV_CYCLES << SHIFT);
    a_rate_code: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R4]
      state.ctrl.rate_code == 3'(k) |-> sample_div_out == EXP_DIV)
      else $error("rate divider wrong");
  end

  // a tick is a single-cycle pulse
  a_tick_paced: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R5]
    sample_tick_out |=> !sample_tick_out)
    else $error("ticks back to back");

  // ticks only come out of an active output
  a_tick_active: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R5]
    sample_tick_out |-> $past(play_enable_out))
    else $error("tick while not active");

  // each tick restarts the sample period
  a_tick_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R5]
    sample_tick_out |-> state.tick_count == 16'h0000)
    else $error("tick without restart");

  // output off with low power set puts the device to sleep
  a_sleep_mode: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R6]
    s_sleep_write |=> sleep_out)
    else $error("sleep not entered");

  // output on means active, whatever the low-power field says
  a_active_mode: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R6]
    s_active_write |=> play_enable_out && !sleep_out)
    else $error("active not entered");

  // output off with low power clear leaves the device idle
  a_idle_mode: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R6]
    s_idle_write |=> idle_out)
    else $error("idle not entered");

  // exactly one power mode at a time
  a_power_onehot: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R6]
    $onehot({play_enable_out, sleep_out, idle_out}))
    else $error("power modes overlap");

  // sleep only from the fields that ask for it
  a_sleep_fields: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R6]
    sleep_out |-> !state.ctrl.output_activate && state.ctrl.low_power_select)
    else $error("sleep without request");

  // play only while the output field is set
  a_play_gate: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R6]
    play_enable_out |-> state.ctrl.output_activate)
    else $error("play without output");

  // sleep always carries the clear request to the rest of the device
  a_sleep_clear: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R6]
    sleep_out |-> sleep_clear_out)
    else $error("sleep without clear");

  // leaving reset finds the word cleared and the device idle
  a_reset_values: assert property (@(posedge core_clk_in) // [R6]
    $fell(rst_in) |-> control_word_out == hcw_pkg::CONTROL_WORD_RESET && idle_out)
    else $error("reset values wrong");
endmodule
`default_nettype wire

// ---- tb/hcw_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module hcw_host (
  input wire logic clk_in,
  output logic wr_en_out,
  output logic [3:0] wr_addr_out,
  output logic [11:0] wr_data_out
);
  initial begin
    wr_en_out = 1'b0;
    wr_addr_out = 4'h0;
    wr_data_out = 12'h000;
  end
  // one-cycle strobe; released data is inverted so a stale value cannot pass
  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    wr_addr_out <= a;
    wr_data_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wr_data_out <= ~d;
    @(negedge clk_in);
  endtask
  // address only, no strobe
  task automatic pa(input logic [3:0] a);
    @(posedge clk_in);
    wr_addr_out <= a;
    @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// ---- tb/test_haptic_control_word.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_haptic_control_word;
  logic core_clk_in, rst_in, wr_en_in, wr_allowed_out, sync_enable_out, play_enable_out;
  logic sleep_out, idle_out, sleep_clear_out, sample_tick_out;
  logic [3:0] wr_addr_in;
  logic [11:0] wr_data_in, control_word_out;
  logic [15:0] sample_div_out;
  int errors = 0, check_count = 0, cycles = 0, n;
  hcw_host host (.clk_in(core_clk_in), .wr_en_out(wr_en_in), .wr_addr_out(wr_addr_in),
    .wr_data_out(wr_data_in));
  hcw_control_word i_dut (.core_clk_in, .rst_in, .wr_en_in, .wr_addr_in, .wr_data_in,
    .control_word_out, .wr_allowed_out, .sync_enable_out, .play_enable_out, .sleep_out,
    .idle_out, .sleep_clear_out, .sample_tick_out, .sample_div_out);
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  task automatic test_done;
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // hang guard, well above the fewer than 150 cycles the tests need
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end
  // main sequence
  initial begin
    rst_in = 1'b1;
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(negedge core_clk_in);
    chk(control_word_out, 16'h0000);
    chk(idle_out, 16'h0001);
    host.wr(4'h5, 12'h080);
    chk(sync_enable_out, 16'h0001);
    for (int c = 0; c < 8; c++) begin
      host.wr(4'h5, 12'h010 | 12'(c));
      chk(sample_div_out, (c == 7) ? 16'h0c00 : 16'h0030 << c);
      chk(play_enable_out, 16'h0001);
    end
    chk(sync_enable_out, 16'h0000);
    host.wr(4'h5, 12'h010);
    do @(negedge core_clk_in); while (sample_tick_out !== 1'b1);
    n = 0;
    do begin @(negedge core_clk_in); n++; end while (sample_tick_out !== 1'b1);
    chk(16'(n), 16'h0030);
    host.wr(4'h5, 12'h050);
    host.pa(4'h2);
    chk(wr_allowed_out, 16'h0000);
    host.pa(4'h3);
    chk(wr_allowed_out, 16'h0001);
    host.wr(4'h5, 12'h040);
    host.pa(4'h2);
    chk(wr_allowed_out, 16'h0001);
    host.wr(4'h5, 12'h008);
    chk({sleep_out, sleep_clear_out}, 16'h0003);
    host.wr(4'h5, 12'h000);
    chk(idle_out, 16'h0001);
    test_done();
  end
endmodule
`default_nettype wire
